// *** core/uec_top.sv ***
`include "uec_map.svh"
`default_nettype none

// Functional notes
// - in length register is byte count minus one
// - in length resets to 0x08, nine bytes
// - valid ep0 token sets out-ready bit 0
// - enabled ep0 events raise interrupt status bit
// - only serviced-out bit 6 clears out-ready
// - no data phase while out-ready set
// - cpu sets in-ready; only hardware clears it
// - protocol violation stalls, sets sent-stall bit 2; EP0_STALL_O is driven by force-stall only
// - force-stall bit 3 stalls once, self-clears
// - cpu sets data-end; transfer end clears it
// - early transfer end sets setup-end bit 5
// - bit 7 write clears setup-end
// - receive-service reads one at twelve bytes
// - out packet sets receive-complete, w1c
// - out force-stall answers out tokens stall
// - out status bits 7..6 read zero
// - receive-error set on errors, cleared with complete
// - nak out tokens while receive-complete set
// - oversize out packet sets sent-stall, w1c
// - fifo-not-empty reads one with unread data
module uec_top
    import uec_pkg::*;
#(
    parameter int FIFO_LVL_W = 5
)
(
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire uec_ep0_evt_s EP0_EVT_I,
    input wire uec_out_evt_s OUT_EVT_I,
    input wire logic [FIFO_LVL_W-1:0] RX_FIFO_LEVEL_I,
    output logic [8:0] IN_TX_BYTES_O,
    output logic EP0_DATA_HOLD_O,
    output logic EP0_STALL_O,
    output logic EP0_INT_STATUS_O,
    output logic OUT_NAK_O,
    output logic OUT_STALL_O
);

    uec_wb_req_s req;
    logic wr_stb;
    uec_word_t rdata;

    logic [7:0] in_len_reg;
    logic [7:0] in_len_next;
    logic [8:0] tx_bytes_reg;
    logic [8:0] tx_bytes_next;
    logic ep0_out_ready_reg, ep0_out_ready_next;
    logic ep0_in_ready_reg, ep0_in_ready_next;
    logic ep0_sst_reg, ep0_sst_next;
    logic ep0_fst_reg, ep0_fst_next;
    logic ep0_data_end_reg, ep0_data_end_next;
    logic ep0_setup_end_reg, ep0_setup_end_next;
    logic ep0_int_status_reg, ep0_int_status_next;
    logic ep0_int_en_reg, ep0_int_en_next;
    logic rx_pkt_complete_reg, rx_pkt_complete_next;
    logic rx_pkt_error_reg, rx_pkt_error_next;
    logic out_sst_reg, out_sst_next;
    logic out_fst_reg, out_fst_next;
    logic hold_reg, stall0_reg, nak_reg, stall1_reg, int_out_reg;

    uec_wb_slave u_wb
    (
        .CLK_SYS_I(CLK_SYS_I),
        .NRST_I(NRST_I),
        .cyc_i(WB_CYC_I),
        .stb_i(WB_STB_I),
        .we_i(WB_WE_I),
        .adr_i(WB_ADR_I),
        .sel_i(WB_SEL_I),
        .dat_i(WB_DAT_I),
        .rdata_i(rdata),
        .req_o(req),
        .wr_stb_o(wr_stb),
        .ack_o(WB_ACK_O),
        .dat_o(WB_DAT_O)
    );

    // address decode; only the low byte lane carries register data
    wire hit_len = req.adr == `UEC_OFF_IN_LEN;
    wire hit_ep0 = req.adr == `UEC_OFF_EP0_CS;
    wire hit_out = req.adr == `UEC_OFF_OUT_CS;
    wire hit_int = req.adr == `UEC_OFF_EP0_INT;
    wire wr_lane = wr_stb && req.sel[0];
    wire [7:0] wd = req.dat[7:0];
    wire wr_len = wr_lane && hit_len;
    wire wr_ep0 = wr_lane && hit_ep0;
    wire wr_out = wr_lane && hit_out;
    wire wr_int = wr_lane && hit_int;

    wire so_clr = wr_ep0 && wd[`UEC_EP0_SO];
    wire ipr_set = wr_ep0 && wd[`UEC_EP0_IPR];
    wire sst0_clr = wr_ep0 && wd[`UEC_EP0_SST];
    wire fst0_set = wr_ep0 && wd[`UEC_EP0_FST];
    wire de_set = wr_ep0 && wd[`UEC_EP0_DE];
    wire sse_clr = wr_ep0 && wd[`UEC_EP0_SSE];
    wire rpc_clr = wr_out && wd[`UEC_OUT_RPC];
    wire sst1_clr = wr_out && wd[`UEC_OUT_SST];
    wire int_clr = wr_int && wd[`UEC_INT_STAT];

    wire rx_service = RX_FIFO_LEVEL_I >= FIFO_LVL_W'(`UEC_RFS_LEVEL);
    wire rx_not_empty = RX_FIFO_LEVEL_I != '0;

    // byte count is field plus one
    assign in_len_next = wr_len ? wd : in_len_reg;
    assign tx_bytes_next = {1'b0, in_len_next} + 9'h001;

    // token sets out-ready, set wins over clear
    assign ep0_out_ready_next = EP0_EVT_I.token || (ep0_out_ready_reg && !so_clr);
    // cpu sets, transmit done clears; a fresh load wins
    assign ep0_in_ready_next = ipr_set || (ep0_in_ready_reg && !EP0_EVT_I.in_sent);
    assign ep0_sst_next = EP0_EVT_I.violation || (ep0_sst_reg && !sst0_clr);
    // cleared once the stall handshake went out
    assign ep0_fst_next = fst0_set || (ep0_fst_reg && !EP0_EVT_I.stall_sent);
    assign ep0_data_end_next = de_set || (ep0_data_end_reg && !EP0_EVT_I.xfer_end);
    wire se_set = EP0_EVT_I.xfer_end && !ep0_data_end_reg;
    assign ep0_setup_end_next = se_set || (ep0_setup_end_reg && !sse_clr);

    // interrupt sources, gated by the enable
    wire ipr_hw_clr = ep0_in_ready_reg && EP0_EVT_I.in_sent && !ipr_set;
    wire de_hw_clr = ep0_data_end_reg && EP0_EVT_I.xfer_end && !de_set;
    wire ep0_event = EP0_EVT_I.token || ipr_hw_clr || EP0_EVT_I.violation
        || de_hw_clr || se_set;
    assign ep0_int_status_next = (ep0_int_en_reg && ep0_event)
        || (ep0_int_status_reg && !int_clr);
    assign ep0_int_en_next = wr_int ? wd[`UEC_INT_EN] : ep0_int_en_reg;

    assign rx_pkt_complete_next = OUT_EVT_I.pkt_done || (rx_pkt_complete_reg && !rpc_clr);
    // error latched with completion, cleared with it
    // each completion reloads it, so a clean packet never inherits an old error
    assign rx_pkt_error_next = OUT_EVT_I.pkt_done ? OUT_EVT_I.pkt_err
        : (rx_pkt_error_reg && !rpc_clr);
    assign out_sst_next = OUT_EVT_I.overflow || (out_sst_reg && !sst1_clr);
    assign out_fst_next = wr_out ? wd[`UEC_OUT_FST] : out_fst_reg;

    // read mux; write-only and reserved bits read zero
    wire [7:0] ep0_rd = {2'b00, ep0_setup_end_reg, ep0_data_end_reg, ep0_fst_reg,
        ep0_sst_reg, ep0_in_ready_reg, ep0_out_ready_reg};
    wire [7:0] out_rd = {2'b00, rx_not_empty, out_fst_reg, out_sst_reg,
        rx_pkt_error_reg, rx_pkt_complete_reg, rx_service};
    wire [7:0] int_rd = {6'b00_0000, ep0_int_en_reg, ep0_int_status_reg};
    wire [7:0] rd_byte = hit_len ? in_len_reg
        : hit_ep0 ? ep0_rd
        : hit_out ? out_rd
        : hit_int ? int_rd
        : 8'h00;
    assign rdata = {24'h00_0000, rd_byte};

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
        begin
            in_len_reg <= `UEC_IN_LEN_RST;
            tx_bytes_reg <= {1'b0, `UEC_IN_LEN_RST} + 9'h001;
            {ep0_out_ready_reg, ep0_in_ready_reg, ep0_sst_reg, ep0_fst_reg} <= 4'h0;
            {ep0_data_end_reg, ep0_setup_end_reg, ep0_int_status_reg} <= 3'h0;
            ep0_int_en_reg <= 1'b0;
            {rx_pkt_complete_reg, rx_pkt_error_reg, out_sst_reg, out_fst_reg} <= 4'h0;
        end
        else
        begin
            in_len_reg <= in_len_next;
            tx_bytes_reg <= tx_bytes_next;
            ep0_out_ready_reg <= ep0_out_ready_next;
            ep0_in_ready_reg <= ep0_in_ready_next;
            ep0_sst_reg <= ep0_sst_next;
            ep0_fst_reg <= ep0_fst_next;
            ep0_data_end_reg <= ep0_data_end_next;
            ep0_setup_end_reg <= ep0_setup_end_next;
            ep0_int_status_reg <= ep0_int_status_next;
            ep0_int_en_reg <= ep0_int_en_next;
            rx_pkt_complete_reg <= rx_pkt_complete_next;
            rx_pkt_error_reg <= rx_pkt_error_next;
            out_sst_reg <= out_sst_next;
            out_fst_reg <= out_fst_next;
        end
    end

    // engine-facing mirrors, flopped from the next values so they track the flags
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
        begin
            {hold_reg, stall0_reg, nak_reg, stall1_reg, int_out_reg} <= 5'h00;
        end
        else
        begin
            // data phase held off while out-ready set
            hold_reg <= ep0_out_ready_next;
            stall0_reg <= ep0_fst_next;
            nak_reg <= rx_pkt_complete_next;
            // stall persists until both force and sent stall are cleared
            stall1_reg <= out_fst_next || out_sst_next;
            int_out_reg <= ep0_int_status_next;
        end
    end

    assign IN_TX_BYTES_O = tx_bytes_reg;
    assign EP0_DATA_HOLD_O = hold_reg;
    assign EP0_STALL_O = stall0_reg;
    assign OUT_NAK_O = nak_reg;
    assign OUT_STALL_O = stall1_reg;
    assign EP0_INT_STATUS_O = int_out_reg;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!NRST_I);

    chk_len_count: assert property (IN_TX_BYTES_O == {1'b0, in_len_reg} + 9'h001)
        else $error("in byte count not length plus one");
    chk_len_reset: assert property (disable iff (1'b0) !NRST_I
        |=> in_len_reg == `UEC_IN_LEN_RST && IN_TX_BYTES_O == {1'b0, `UEC_IN_LEN_RST} + 9'h001)
        else $error("in length reset value wrong");
    chk_opr_set: assert property (EP0_EVT_I.token |=> ep0_out_ready_reg && EP0_DATA_HOLD_O)
        else $error("token did not set out-ready");
    chk_int_raise: assert property (ep0_int_en_reg && ep0_event |=> EP0_INT_STATUS_O)
        else $error("ep0 event did not raise interrupt status");
    chk_opr_hold: assert property (ep0_out_ready_reg && !so_clr |=> ep0_out_ready_reg)
        else $error("out-ready cleared without serviced-out");
    chk_hold_phase: assert property (ep0_out_ready_reg |-> EP0_DATA_HOLD_O)
        else $error("data phase not held while out-ready");
    chk_ipr_keep: assert property (ep0_in_ready_reg && !EP0_EVT_I.in_sent
        |=> ep0_in_ready_reg)
        else $error("in-ready cleared by other than transmit");
    chk_sst_set: assert property (EP0_EVT_I.violation |=> ep0_sst_reg)
        else $error("violation did not set sent-stall");
    chk_fst_self: assert property (ep0_fst_reg && EP0_EVT_I.stall_sent && !fst0_set
        |=> !ep0_fst_reg && !EP0_STALL_O)
        else $error("force stall not self-cleared");
    chk_de_end: assert property (ep0_data_end_reg && EP0_EVT_I.xfer_end && !de_set
        |=> !ep0_data_end_reg)
        else $error("data-end not cleared at transfer end");
    chk_se_early: assert property (EP0_EVT_I.xfer_end && !ep0_data_end_reg
        |=> ep0_setup_end_reg)
        else $error("early end did not set setup-end");
    chk_rpc_nak: assert property (OUT_EVT_I.pkt_done |=> rx_pkt_complete_reg ##0 OUT_NAK_O)
        else $error("no nak after packet complete");
    chk_rpe_with: assert property (rx_pkt_error_reg |-> rx_pkt_complete_reg)
        else $error("receive error without complete");
    chk_out_stall: assert property (out_fst_reg |-> OUT_STALL_O)
        else $error("force stall not answered with stall");
    chk_oversize: assert property (OUT_EVT_I.overflow |=> out_sst_reg [*2] or
        (out_sst_reg ##1 $fell(out_sst_reg)))
        else $error("oversize did not set sent-stall");
    // a one-cycle ack keeps a still-held request from being taken twice
    chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    // the master still holds the address while ack stands
    chk_out_rsvd: assert property (WB_ACK_O && hit_out && !req.we
        |-> WB_DAT_O[7:6] == 2'b00)
        else $error("out status reserved bits read nonzero");
    chk_se_clear: assert property (ep0_setup_end_reg && sse_clr && !se_set
        |=> !ep0_setup_end_reg)
        else $error("serviced setup end did not clear setup-end");
    chk_rfs_level: assert property (out_rd[`UEC_OUT_RFS]
        == (RX_FIFO_LEVEL_I >= FIFO_LVL_W'(`UEC_RFS_LEVEL)))
        else $error("receive-service bit disagrees with fifo level");
    chk_rne_data: assert property (out_rd[`UEC_OUT_RNE] == (RX_FIFO_LEVEL_I != '0))
        else $error("fifo-not-empty bit disagrees with fifo level");
    chk_rpc_clear: assert property (rpc_clr && !OUT_EVT_I.pkt_done
        |=> !rx_pkt_complete_reg && !rx_pkt_error_reg && !OUT_NAK_O)
        else $error("receive-complete not cleared by write");
    chk_sst_keep: assert property (ep0_sst_reg && wr_ep0 && !wd[`UEC_EP0_SST]
        |=> ep0_sst_reg)
        else $error("zero write cleared sent-stall");
    chk_nak_level: assert property (rx_pkt_complete_reg |-> OUT_NAK_O)
        else $error("no nak while receive-complete set");
    chk_stall_both: assert property (out_sst_reg |-> OUT_STALL_O)
        else $error("sent-stall set but out tokens not stalled");
    chk_ipr_clear: assert property (ep0_in_ready_reg && EP0_EVT_I.in_sent && !ipr_set
        |=> !ep0_in_ready_reg)
        else $error("in-ready not cleared after transmit");

endmodule // uec_top

`default_nettype wire

// *** core/uec_map.svh ***
`ifndef UEC_MAP_SVH
`define UEC_MAP_SVH

// register byte addresses
`define UEC_OFF_IN_LEN 32'h8000_000C
`define UEC_OFF_EP0_CS 32'h8000_0010
`define UEC_OFF_OUT_CS 32'h8000_0014
`define UEC_OFF_EP0_INT 32'h8000_0030

// reset values
`define UEC_IN_LEN_RST 8'h08
`define UEC_CS_RST 8'h00

// control endpoint status bits
`define UEC_EP0_OPR 0
`define UEC_EP0_IPR 1
`define UEC_EP0_SST 2
`define UEC_EP0_FST 3
`define UEC_EP0_DE 4
`define UEC_EP0_SE 5
`define UEC_EP0_SO 6
`define UEC_EP0_SSE 7

// out endpoint status bits
`define UEC_OUT_RFS 0
`define UEC_OUT_RPC 1
`define UEC_OUT_RPE 2
`define UEC_OUT_SST 3
`define UEC_OUT_FST 4
`define UEC_OUT_RNE 5

// interrupt status/enable bits
`define UEC_INT_STAT 0
`define UEC_INT_EN 1

// receive fifo service threshold in bytes
`define UEC_RFS_LEVEL 5'h0C

`endif

// *** core/uec_pkg.sv ***
`default_nettype none

package uec_pkg;

    typedef logic [31:0] uec_word_t;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
    } uec_wb_req_s;

    // pulses from the control endpoint transaction engine
    typedef struct packed {
        logic token;
        logic in_sent;
        logic violation;
        logic stall_sent;
        logic xfer_end;
    } uec_ep0_evt_s;

    // pulses from the out endpoint receive engine
    typedef struct packed {
        logic pkt_done;
        logic pkt_err;
        logic overflow;
    } uec_out_evt_s;

endpackage : uec_pkg

`default_nettype wire

// *** core/uec_wb_slave.sv ***
`default_nettype none

module uec_wb_slave
    import uec_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire uec_word_t rdata_i,
    output uec_wb_req_s req_o,
    output logic wr_stb_o,
    output logic ack_o,
    output logic [31:0] dat_o
);

    logic ack_reg;
    logic ack_next;
    logic [31:0] dat_reg;
    logic [31:0] dat_next;
    wire req_new;

    // one answer per request; ack drops the cycle after it was given
    assign req_new = cyc_i && stb_i && !ack_reg;
    assign ack_next = req_new;
    assign dat_next = (req_new && !we_i) ? rdata_i : dat_reg;
    assign wr_stb_o = req_new && we_i;
    assign req_o = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i};
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    always_ff @(posedge CLK_SYS_I)
    begin
        if (!NRST_I)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

endmodule // uec_wb_slave

`default_nettype wire

// *** tb/uec_host_model.sv ***
`default_nettype none

module uec_host_model
    import uec_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire uec_ep0_evt_s ep0_req_i,
    input wire uec_out_evt_s out_req_i,
    input wire logic hold_i,
    input wire logic nak_i,
    output uec_ep0_evt_s ep0_evt_o,
    output uec_out_evt_s out_evt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            ep0_evt_o <= '0;
            out_evt_o <= '0;
        end
        else
        begin
            ep0_evt_o <= ep0_req_i & {1'b1, ~hold_i, 3'b111};
            out_evt_o <= out_req_i & {~nak_i, ~nak_i, 1'b1};
        end
    end
endmodule // uec_host_model

`default_nettype wire

// *** tb/usb_endpoint_control_status_tb_top.sv ***
`include "uec_map.svh"
`default_nettype none

module usb_endpoint_control_status_tb_top
    import uec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = 32'h0000_0000;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'h0;
    logic [4:0] level = 5'h00;
    uec_ep0_evt_s ep0_req = '0;
    uec_out_evt_s out_req = '0;
    uec_ep0_evt_s ep0_evt;
    uec_out_evt_s out_evt;
    logic [31:0] WB_DAT_O;
    logic WB_ACK_O;
    logic [8:0] IN_TX_BYTES_O;
    logic hold, stall, irq, nak, ostall;
    logic [31:0] rd;
    logic [7:0] v;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed = 32'ha3b1_6ef0;

    uec_host_model uec_host_model_inst (.clk_i(clk), .nrst_i(nrst), .ep0_req_i(ep0_req),
        .out_req_i(out_req), .hold_i(hold), .nak_i(nak), .ep0_evt_o(ep0_evt),
        .out_evt_o(out_evt));

    uec_top #(.FIFO_LVL_W(5)) uec_top_inst (.CLK_SYS_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EP0_EVT_I(ep0_evt), .OUT_EVT_I(out_evt),
        .RX_FIFO_LEVEL_I(level), .IN_TX_BYTES_O(IN_TX_BYTES_O), .EP0_DATA_HOLD_O(hold),
        .EP0_STALL_O(stall), .EP0_INT_STATUS_O(irq), .OUT_NAK_O(nak), .OUT_STALL_O(ostall));

    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic conclude;
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bchk(input logic got, input logic exp);
        chk({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask

    function automatic logic [31:0] tx_bytes(input logic [7:0] len);
        return {24'h00_0000, len} + 32'h0000_0001;
    endfunction

    function automatic logic [7:0] rx_stat(input logic [4:0] l);
        return {2'b00, (l != 5'h00), 4'h0, (l >= 5'h0C)};
    endfunction

    // request held until ack sampled; read data taken at that edge
    task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        sel <= 4'hF;
        // only ack or the bench timeout ends this wait
        do
        begin
            @(posedge clk);
        end
        while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, e});
    endtask

    // one-cycle pulse through the engine model, flags settled on return
    task automatic evt(input uec_ep0_evt_s e, input uec_out_evt_s o);
        @(posedge clk);
        ep0_req <= e;
        out_req <= o;
        @(posedge clk);
        ep0_req <= '0;
        out_req <= '0;
        @(posedge clk);
        #1;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rchk(`UEC_OFF_IN_LEN, 8'h08);
        chk({23'h00_0000, IN_TX_BYTES_O}, tx_bytes(8'h08));
        rchk(`UEC_OFF_EP0_CS, 8'h00);
        rchk(`UEC_OFF_OUT_CS, 8'h00);
        for (int i = 0; i < 12; i++)
        begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            wb(1'b1, `UEC_OFF_IN_LEN, v);
            rchk(`UEC_OFF_IN_LEN, v);
            chk({23'h00_0000, IN_TX_BYTES_O}, tx_bytes(v));
        end
        wb(1'b1, `UEC_OFF_EP0_INT, 8'h02);
        evt(5'h10, 3'h0);
        bchk(hold, 1'b1);
        bchk(irq, 1'b1);
        rchk(`UEC_OFF_EP0_CS, 8'h01);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h00);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h80);
        rchk(`UEC_OFF_EP0_CS, 8'h01);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h40);
        rchk(`UEC_OFF_EP0_CS, 8'h00);
        bchk(hold, 1'b0);
        wb(1'b1, `UEC_OFF_EP0_INT, 8'h03);
        rchk(`UEC_OFF_EP0_INT, 8'h02);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h02);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h00);
        rchk(`UEC_OFF_EP0_CS, 8'h02);
        evt(5'h08, 3'h0);
        rchk(`UEC_OFF_EP0_CS, 8'h00);
        bchk(irq, 1'b1);
        wb(1'b1, `UEC_OFF_EP0_INT, 8'h03);
        evt(5'h04, 3'h0);
        rchk(`UEC_OFF_EP0_CS, 8'h04);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h04);
        rchk(`UEC_OFF_EP0_CS, 8'h00);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h08);
        bchk(stall, 1'b1);
        evt(5'h02, 3'h0);
        rchk(`UEC_OFF_EP0_CS, 8'h00);
        bchk(stall, 1'b0);
        evt(5'h10, 3'h0);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h50);
        rchk(`UEC_OFF_EP0_CS, 8'h10);
        evt(5'h01, 3'h0);
        rchk(`UEC_OFF_EP0_CS, 8'h00);
        // early end arriving with a new setup token
        evt(5'h11, 3'h0);
        rchk(`UEC_OFF_EP0_CS, 8'h21);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h80);
        rchk(`UEC_OFF_EP0_CS, 8'h01);
        wb(1'b1, `UEC_OFF_EP0_CS, 8'h40);
        rchk(`UEC_OFF_EP0_CS, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            level <= (i == 0) ? 5'h0C : (i == 1) ? 5'h0B : 5'($unsigned($random(seed)) % 21);
            @(posedge clk);
            rchk(`UEC_OFF_OUT_CS, rx_stat(level));
        end
        level <= 5'h00;
        evt(5'h00, 3'h6);
        rchk(`UEC_OFF_OUT_CS, 8'h06);
        bchk(nak, 1'b1);
        wb(1'b1, `UEC_OFF_OUT_CS, 8'h02);
        rchk(`UEC_OFF_OUT_CS, 8'h00);
        bchk(nak, 1'b0);
        evt(5'h00, 3'h1);
        rchk(`UEC_OFF_OUT_CS, 8'h08);
        bchk(ostall, 1'b1);
        wb(1'b1, `UEC_OFF_OUT_CS, 8'h08);
        rchk(`UEC_OFF_OUT_CS, 8'h00);
        wb(1'b1, `UEC_OFF_OUT_CS, 8'hD0);
        rchk(`UEC_OFF_OUT_CS, 8'h10);
        bchk(ostall, 1'b1);
        wb(1'b1, `UEC_OFF_OUT_CS, 8'h00);
        bchk(ostall, 1'b0);
        rchk(32'h8000_0020, 8'h00);
        // mid-run reset must restore the nine-byte length
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rchk(`UEC_OFF_IN_LEN, 8'h08);
        chk({23'h00_0000, IN_TX_BYTES_O}, tx_bytes(8'h08));
        conclude();
    end
endmodule // usb_endpoint_control_status_tb_top

`default_nettype wire
